/* File: rtl/pllcc_pkg.sv */
package pllcc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_LPO_TRIM = 8'h3c;
   localparam logic [7:0] ADDR_PLL_CONTROL = 8'h3d;
   localparam logic [7:0] ADDR_PLL_OUTPUT_DIVIDER = 8'h3e;
   localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h50;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_LPO_TRIM = 8'h00;
   localparam logic [7:0] RST_PLL_CONTROL = 8'h00;
   localparam logic [7:0] RST_PLL_OUTPUT_DIVIDER = 8'h08;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 4;
   localparam int PIN_EN_BIT = 3;
   localparam int PD_BIT = 2;
   localparam int FB_MSB = 1;
   localparam int FB_LSB = 0;

   // Status register fields
   localparam int ST_PLL_RUN_BIT = 0;
   localparam int ST_PIN_CLK_BIT = 1;
   localparam int ST_PIN_LVL_BIT = 2;

   // ----------------------------------------------------------------
   // Pin source select codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_GPIO = 4'h0;
   localparam logic [3:0] SEL_PLL = 4'h1;
   localparam logic [3:0] SEL_LOW = 4'h2;
   localparam logic [3:0] SEL_HIGH = 4'h3;
   localparam logic [3:0] SEL_XTAL_FIRST = 4'h4;
   localparam logic [3:0] SEL_XTAL_LAST = 4'h7;
   localparam logic [3:0] SEL_TIMER_FIRST = 4'h8;
   localparam logic [3:0] SEL_TIMER_LAST = 4'hb;

   // ----------------------------------------------------------------
   // Feedback divider codes and factors
   // ----------------------------------------------------------------
   localparam logic [1:0] FB_CODE_27 = 2'h1;
   localparam logic [1:0] FB_CODE_28 = 2'h2;
   localparam logic [4:0] FB_FACTOR_23 = 5'h17;
   localparam logic [4:0] FB_FACTOR_27 = 5'h1b;
   localparam logic [4:0] FB_FACTOR_28 = 5'h1c;

   // Smallest legal post divider factor
   localparam logic [7:0] POST_DIV_MIN = 8'h08;

   // Crystal frequency in kHz
   localparam logic [19:0] XTAL_KHZ = 20'h069f0;

endpackage : pllcc_pkg

/* File: rtl/pllcc_post_div.sv */
`timescale 1ns/1ps
`default_nettype none

module pllcc_post_div (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_tick,
   input wire logic [7:0] i_factor,
   output logic o_clk
);

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic out_reg;
   wire logic wrap = (cnt_reg >= (i_factor - 8'h01));

   assign cnt_next = wrap ? 8'h00 : cnt_reg + 8'h01;
   assign o_clk = out_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run) begin
         cnt_reg <= 8'h00;
         out_reg <= 1'b0;
      end else if (i_tick) begin
         cnt_reg <= cnt_next;
         out_reg <= (cnt_next < {1'b0, i_factor[7:1]});
      end
   end

endmodule : pllcc_post_div

`default_nettype wire

/* File: rtl/pllcc_xtal_div.sv */
`timescale 1ns/1ps
`default_nettype none

module pllcc_xtal_div (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_xtal,
   output logic [3:0] o_div
);

   logic xtal_reg;
   logic [2:0] cnt_reg;
   wire logic rise = i_xtal && !xtal_reg;

   // Divide by 1, 2, 4, 8 in bits 0 to 3
   assign o_div = {cnt_reg, xtal_reg};

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         xtal_reg <= 1'b0;
         cnt_reg <= 3'h0;
      end else begin
         xtal_reg <= i_xtal;
         if (rise) begin
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end

endmodule : pllcc_xtal_div

`default_nettype wire

/* File: rtl/pllcc_top.sv */
// Function
// - Eight-bit read/write oscillator trim; larger value means lower frequency.
// - First PLL stage: crystal times feedback factor, then halved.
// - Second PLL stage divides first stage by post divider value.
// - Select 0 gives pin to I/O, 1 PLL, 2 low, 3 high.
// - Select 4 to 7 show crystal divided by 1, 2, 4, 8.
// - Select 8 to B toggle pin on overflow of timer 0 to 3.
// - Clock drives pin only while control bit 3 enable is set.
// - Feedback code 00 gives 23, 01 gives 27, 10 gives 28, 11 gives 23.
// - Post divider divides by own value 8 to 254; 0 to 7 reserved.
// - Control: select 7:4, enable 3, power-down 2, feedback 1:0.
// - Pin general output enable switches clock function off on the pin.
`timescale 1ns/1ps
`default_nettype none

module pllcc_top (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_xtal,
   input wire logic i_pll_stage1_tick,
   input wire logic [3:0] i_timer_overflow,
   input wire logic i_clock_pin_gpio_enable,
   input wire logic i_clock_pin_gpio_out,
   input wire logic i_clock_output_pin_i,
   output logic o_clock_output_pin_o,
   output logic o_clock_output_pin_oe,
   output logic [7:0] o_lpo_trim,
   output logic o_pll_power_down,
   output logic [4:0] o_pll_feedback_factor,
   output logic [18:0] o_pll_stage1_khz,
   output logic [7:0] o_pll_post_divider
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] fb_factor(input logic [1:0] code);
      logic [4:0] f;
      f = pllcc_pkg::FB_FACTOR_23;
      if (code == pllcc_pkg::FB_CODE_27) begin
         f = pllcc_pkg::FB_FACTOR_27;
      end else if (code == pllcc_pkg::FB_CODE_28) begin
         f = pllcc_pkg::FB_FACTOR_28;
      end
      return f;
   endfunction : fb_factor

   function automatic logic in_range(input logic [3:0] v,
                                     input logic [3:0] lo,
                                     input logic [3:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_range

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] lpo_trim_reg;
   logic [7:0] pll_control_reg;
   logic [7:0] pll_output_divider_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   wire logic wr_trim = i_wr && (i_addr == pllcc_pkg::ADDR_LPO_TRIM);
   wire logic wr_ctrl = i_wr && (i_addr == pllcc_pkg::ADDR_PLL_CONTROL);
   wire logic wr_div = i_wr &&
      (i_addr == pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lpo_trim_reg <= pllcc_pkg::RST_LPO_TRIM;
         pll_control_reg <= pllcc_pkg::RST_PLL_CONTROL;
         pll_output_divider_reg <= pllcc_pkg::RST_PLL_OUTPUT_DIVIDER;
      end else begin
         if (wr_trim) begin
            lpo_trim_reg <= i_wdata;
         end
         if (wr_ctrl) begin
            pll_control_reg <= i_wdata;
         end
         if (wr_div) begin
            pll_output_divider_reg <= i_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   wire logic [3:0] clock_pin_source_select =
      pll_control_reg[pllcc_pkg::SEL_MSB:pllcc_pkg::SEL_LSB];
   wire logic clock_pin_enable =
      pll_control_reg[pllcc_pkg::PIN_EN_BIT];
   wire logic pll_power_down =
      pll_control_reg[pllcc_pkg::PD_BIT];
   wire logic [1:0] pll_feedback_divider =
      pll_control_reg[pllcc_pkg::FB_MSB:pllcc_pkg::FB_LSB];

   // ----------------------------------------------------------------
   // PLL model
   // ----------------------------------------------------------------
   logic [4:0] fb_factor_reg;
   logic [18:0] stage1_khz_reg;
   logic pll_clk;

   wire logic [4:0] fb_factor_now = fb_factor(pll_feedback_divider);
   wire logic [19:0] stage1_product =
      pllcc_pkg::XTAL_KHZ * {15'h0000, fb_factor_now};
   wire logic [18:0] stage1_khz = stage1_product[19:1];

   // Reserved low settings are held at the smallest legal factor
   wire logic [7:0] pll_post_divider =
      (pll_output_divider_reg < pllcc_pkg::POST_DIV_MIN) ?
      pllcc_pkg::POST_DIV_MIN : pll_output_divider_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fb_factor_reg <= pllcc_pkg::FB_FACTOR_23;
         stage1_khz_reg <= 19'h00000;
      end else begin
         fb_factor_reg <= fb_factor_now;
         stage1_khz_reg <= pll_power_down ? 19'h00000 : stage1_khz;
      end
   end

   pllcc_post_div u_post_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_run(!pll_power_down),
      .i_tick(i_pll_stage1_tick),
      .i_factor(pll_post_divider),
      .o_clk(pll_clk)
   );

   // ----------------------------------------------------------------
   // Crystal dividers
   // ----------------------------------------------------------------
   logic [3:0] xtal_div;

   pllcc_xtal_div u_xtal_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_xtal(i_xtal),
      .o_div(xtal_div)
   );

   // ----------------------------------------------------------------
   // Timer overflow toggle
   // ----------------------------------------------------------------
   logic timer_toggle_reg;

   wire logic sel_timer = in_range(clock_pin_source_select,
      pllcc_pkg::SEL_TIMER_FIRST, pllcc_pkg::SEL_TIMER_LAST);
   wire logic [1:0] timer_idx = clock_pin_source_select[1:0];
   wire logic timer_hit = sel_timer && i_timer_overflow[timer_idx];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         timer_toggle_reg <= 1'b0;
      end else if (timer_hit) begin
         timer_toggle_reg <= !timer_toggle_reg;
      end
   end

   // ----------------------------------------------------------------
   // Pin source multiplexer
   // ----------------------------------------------------------------
   wire logic sel_xtal = in_range(clock_pin_source_select,
      pllcc_pkg::SEL_XTAL_FIRST, pllcc_pkg::SEL_XTAL_LAST);
   wire logic sel_pll = (clock_pin_source_select == pllcc_pkg::SEL_PLL);
   wire logic sel_low = (clock_pin_source_select == pllcc_pkg::SEL_LOW);
   wire logic sel_high = (clock_pin_source_select == pllcc_pkg::SEL_HIGH);
   wire logic sel_gpio = (clock_pin_source_select == pllcc_pkg::SEL_GPIO);

   // Codes with a defined clock source; C to F are left out
   wire logic sel_defined = sel_pll || sel_low || sel_high || sel_xtal ||
      sel_timer;

   wire logic xtal_pick = xtal_div[clock_pin_source_select[1:0]];

   wire logic clk_level =
      sel_pll ? pll_clk :
      sel_high ? 1'b1 :
      sel_xtal ? xtal_pick :
      sel_timer ? timer_toggle_reg :
      1'b0;

   // General I/O owns the pin on code 0 or when its output is enabled
   wire logic pin_is_gpio = sel_gpio || i_clock_pin_gpio_enable;

   wire logic pin_drive_clock = !pin_is_gpio && clock_pin_enable &&
      sel_defined;

   wire logic pin_o_next = pin_is_gpio ? i_clock_pin_gpio_out :
      (pin_drive_clock ? clk_level : 1'b0);
   wire logic pin_oe_next = pin_is_gpio ? i_clock_pin_gpio_enable :
      pin_drive_clock;

   logic pin_o_reg;
   logic pin_oe_reg;
   logic pin_clk_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_o_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
         pin_clk_reg <= 1'b0;
      end else begin
         pin_o_reg <= pin_o_next;
         pin_oe_reg <= pin_oe_next;
         pin_clk_reg <= pin_drive_clock;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire logic [7:0] status_word = {5'h00,
      i_clock_output_pin_i,
      pin_clk_reg,
      !pll_power_down};

   always_comb begin
      rdata_next = 8'h00;
      unique case (i_addr)
         pllcc_pkg::ADDR_LPO_TRIM: rdata_next = lpo_trim_reg;
         pllcc_pkg::ADDR_PLL_CONTROL: rdata_next = pll_control_reg;
         pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER:
            rdata_next = pll_output_divider_reg;
         pllcc_pkg::ADDR_CLOCK_STATUS: rdata_next = status_word;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_reg <= 8'h00;
      end else if (i_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rdata = rdata_reg;
   assign o_clock_output_pin_o = pin_o_reg;
   assign o_clock_output_pin_oe = pin_oe_reg;
   assign o_lpo_trim = lpo_trim_reg;
   assign o_pll_power_down = pll_power_down;
   assign o_pll_feedback_factor = fb_factor_reg;
   assign o_pll_stage1_khz = stage1_khz_reg;
   assign o_pll_post_divider = pll_post_divider;

endmodule : pllcc_top

`default_nettype wire

/* File: bench/pllcc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pllcc_props (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_xtal,
   input wire logic [3:0] i_timer_overflow,
   input wire logic i_clock_pin_gpio_enable,
   input wire logic i_clock_pin_gpio_out,
   input wire logic o_clock_output_pin_o,
   input wire logic o_clock_output_pin_oe,
   input wire logic [7:0] o_lpo_trim,
   input wire logic o_pll_power_down,
   input wire logic [4:0] o_pll_feedback_factor,
   input wire logic [7:0] o_pll_post_divider
);
   // ------
   // Shadow of the control register
   // ------
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   wire logic wr_ctl = i_wr && i_addr == pllcc_pkg::ADDR_PLL_CONTROL;
   wire logic [3:0] sel = ctl_reg[7:4];
   wire logic gp = i_clock_pin_gpio_enable;
   wire logic clk_on = ctl_reg[3] && !gp;
   wire logic lvl = clk_on && sel[3:1] == 3'h1;
   wire logic x4 = clk_on && sel == 4'h4;
   wire logic tmr = clk_on && sel[3:2] == 2'h2 && i_timer_overflow[sel[1:0]];
   wire logic quiet = !gp && (!ctl_reg[3] || sel == 4'h0 || sel[3:2] == 2'h3);
   assign ctl_next = wr_ctl ? i_wdata : ctl_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctl_reg <= 8'h00;
      end else begin
         ctl_reg <= ctl_next;
      end
   end
   function automatic logic [4:0] fbf(input logic [1:0] c);
      return c == 2'h1 ? 5'h1b : (c == 2'h2 ? 5'h1c : 5'h17);
   endfunction : fbf
   // ------
   // Checks
   // ------
   default clocking dcb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   a_read_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_trim_read: assert property (
      i_rd && i_addr == pllcc_pkg::ADDR_LPO_TRIM |=> o_rdata == $past(o_lpo_trim))
      else $error("trim read data wrong");
   a_trim_write: assert property (
      i_wr && i_addr == pllcc_pkg::ADDR_LPO_TRIM |=> o_lpo_trim == $past(i_wdata))
      else $error("trim not written");
   a_pd_write: assert property (
      wr_ctl |=> o_pll_power_down == $past(i_wdata[2]))
      else $error("power down bit wrong");
   a_fb_factor: assert property (
      wr_ctl |-> ##2 o_pll_feedback_factor == fbf($past(i_wdata[1:0], 2)))
      else $error("feedback factor wrong");
   a_post_div: assert property (
      i_wr && i_addr == pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER |=>
      o_pll_post_divider == ($past(i_wdata) < 8'h08 ? 8'h08 : $past(i_wdata)))
      else $error("post divider wrong");
   a_pin_level: assert property (
      lvl |=> o_clock_output_pin_oe && o_clock_output_pin_o == $past(sel[0]))
      else $error("fixed pin level wrong");
   a_pin_quiet: assert property (quiet |=> !o_clock_output_pin_oe)
      else $error("pin driven while off");
   a_gpio_wins: assert property (
      gp |=> o_clock_output_pin_oe &&
      o_clock_output_pin_o == $past(i_clock_pin_gpio_out))
      else $error("general output not on pin");
   a_timer_toggle: assert property (
      tmr ##1 $stable(ctl_reg) |=> o_clock_output_pin_o != $past(o_clock_output_pin_o))
      else $error("pin not toggled by timer");
   a_xtal_follow: assert property (
      x4 ##1 x4 |=> o_clock_output_pin_o == $past(i_xtal, 2))
      else $error("crystal not on pin");
endmodule : pllcc_props
bind pllcc_top pllcc_props u_props (.*);
`default_nettype wire

/* File: bench/pll_clock_output_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pll_clock_output_config_tb;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_xtal = 1'b0;
   logic i_pll_stage1_tick = 1'b1;
   logic [3:0] i_timer_overflow = 4'h0;
   logic i_clock_pin_gpio_enable = 1'b0;
   logic i_clock_pin_gpio_out = 1'b0;
   logic i_clock_output_pin_i = 1'b0;
   logic [7:0] o_rdata;
   logic o_clock_output_pin_o;
   logic o_clock_output_pin_oe;
   logic [7:0] o_lpo_trim;
   logic o_pll_power_down;
   logic [4:0] o_pll_feedback_factor;
   logic [18:0] o_pll_stage1_khz;
   logic [7:0] o_pll_post_divider;
   logic [7:0] exp_q[$];
   logic rd_q = 1'b0;
   logic p;
   logic [7:0] v;
   int n_fail = 0;
   int tests_run = 0;
   int seed = 32'hbf0a4f02;
   int e;
   int r;
   pllcc_top u_dut (.*);
   always #2 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      i_xtal <= ~i_xtal;
      i_clock_output_pin_i <= 1'($random(seed));
   end
   // ------
   // Bus and compare tasks
   // ------
   task automatic check(input string s, input logic [31:0] x,
                        input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", s, x, g);
      end
   endtask : check
   // Read data settle after the launching edge; look mid-cycle
   always @(negedge i_clk) begin
      if (rd_q) check("o_rdata", exp_q.pop_front(), o_rdata);
   end
   always @(posedge i_clk) begin
      rd_q <= i_rd;
   end
   task automatic bus(input logic w, input logic [7:0] a, d, x);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      if (!w) exp_q.push_back(x);
      @(posedge i_clk);
   endtask : bus
   task automatic idle(input int c);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (c) @(posedge i_clk);
      #1;
   endtask : idle
   task automatic rises(input int x);
      r = 0;
      p = o_clock_output_pin_o;
      repeat (64) begin
         @(posedge i_clk);
         #1;
         if (o_clock_output_pin_o === 1'b1 && p === 1'b0) r++;
         p = o_clock_output_pin_o;
      end
      if (r >= x - 1 && r <= x + 1) r = x;
      check("rises", x, r);
   endtask : rises
   task automatic end_of_test();
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #40000;
      n_fail++;
      end_of_test();
   end
   // ------
   // Scenarios
   // ------
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      bus(0, pllcc_pkg::ADDR_LPO_TRIM, 0, 8'h00);
      bus(0, pllcc_pkg::ADDR_PLL_CONTROL, 0, 8'h00);
      bus(0, pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER, 0, 8'h08);
      bus(1, 8'h77, 8'h5a, 0);
      bus(0, 8'h77, 0, 8'h00);
      repeat (8) begin
         v = 8'($random(seed));
         bus(1, pllcc_pkg::ADDR_LPO_TRIM, v, 0);
         bus(0, pllcc_pkg::ADDR_LPO_TRIM, 0, v);
         bus(1, pllcc_pkg::ADDR_PLL_CONTROL, v, 0);
         bus(0, pllcc_pkg::ADDR_PLL_CONTROL, 0, v);
         v = 8'(8 + {$random(seed)} % 247);
         bus(1, pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER, v, 0);
         bus(0, pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER, 0, v);
      end
      bus(1, pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER, 8'h08, 0);
      bus(0, pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER, 0, 8'h08);
      for (int c = 0; c < 8; c++) begin
         bus(1, pllcc_pkg::ADDR_PLL_CONTROL, 8'(c), 0);
         idle(3);
         e = c[1:0] == 2'h1 ? 27 : (c[1:0] == 2'h2 ? 28 : 23);
         check("fb", e, o_pll_feedback_factor);
         check("pd", c[2], o_pll_power_down);
         check("khz", c[2] ? 0 : 27120 * e / 2, o_pll_stage1_khz);
      end
      for (int c = 0; c < 16; c++) begin
         bus(1, pllcc_pkg::ADDR_PLL_CONTROL, {4'(c), 4'h8}, 0);
         idle(4);
         check("oe", c >= 1 && c <= 11, o_clock_output_pin_oe);
         if (c == 2 || c == 3) check("pin", c & 1, o_clock_output_pin_o);
         e = c == 1 ? 8 : (c >= 4 && c <= 7 ? 32 >> (c - 4) : 0);
         rises(e);
      end
      bus(1, pllcc_pkg::ADDR_PLL_OUTPUT_DIVIDER, 8'd10, 0);
      bus(1, pllcc_pkg::ADDR_PLL_CONTROL, 8'h18, 0);
      idle(4);
      rises(6);
      bus(1, pllcc_pkg::ADDR_PLL_CONTROL, 8'h1c, 0);
      idle(4);
      rises(0);
      bus(1, pllcc_pkg::ADDR_PLL_CONTROL, 8'h10, 0);
      idle(4);
      check("oe", 0, o_clock_output_pin_oe);
      i_clock_pin_gpio_enable <= 1'b1;
      repeat (4) begin
         i_clock_pin_gpio_out <= 1'($random(seed));
         idle(2);
         check("oe", 1, o_clock_output_pin_oe);
         check("pin", i_clock_pin_gpio_out, o_clock_output_pin_o);
      end
      i_clock_pin_gpio_enable <= 1'b0;
      for (int t = 0; t < 4; t++) begin
         bus(1, pllcc_pkg::ADDR_PLL_CONTROL, {4'(8 + t), 4'h8}, 0);
         idle(3);
         p = o_clock_output_pin_o;
         i_timer_overflow <= 4'(1 << ((t + 1) % 4));
         idle(1);
         i_timer_overflow <= 4'(1 << t);
         idle(1);
         i_timer_overflow <= 4'h0;
         idle(1);
         check("pin", !p, o_clock_output_pin_o);
      end
      idle(2);
      end_of_test();
   end
endmodule : pll_clock_output_config_tb
`default_nettype wire
